// ### rtl/sric_periodic_timer.v
`timescale 1ns/1ps
`include "sric_regs.vh"

module sric_periodic_timer (
  input wire i_clk,
  input wire i_rst,
  input wire i_tick,
  input wire [2:0] i_period_select,
  output reg o_expire
);

  // ====================================================================
  // period table
  function [9:0] sric_period;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: sric_period = `SRIC_PER_1;
        3'h2: sric_period = `SRIC_PER_2;
        3'h3: sric_period = `SRIC_PER_3;
        3'h4: sric_period = `SRIC_PER_4;
        3'h5: sric_period = `SRIC_PER_5;
        3'h6: sric_period = `SRIC_PER_6;
        3'h7: sric_period = `SRIC_PER_7;
        default: sric_period = 10'h000;
      endcase
    end
  endfunction

  reg [9:0] count_reg;
  wire running = (i_period_select != 3'h0);

  // ====================================================================
  // counter
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 10'h000;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (!running) begin
        count_reg <= 10'h000;
      end else if (i_tick) begin
        if (count_reg >= sric_period(i_period_select)) begin
          count_reg <= 10'h000;
          o_expire <= 1'b1;
        end else begin
          count_reg <= count_reg + 10'h001;
        end
      end
    end
  end

endmodule // sric_periodic_timer

// ### rtl/sric_top.v
`timescale 1ns/1ps
`include "sric_regs.vh"

module sric_top (
  input wire i_clk,
  input wire i_rst,
  input wire i_supply_below_lo,
  input wire i_supply_below_hi,
  input wire i_warn_below_lo,
  input wire i_warn_below_hi,
  input wire i_reset_pin,
  input wire i_clk_1khz,
  input wire i_clk_32khz,
  input wire i_wdog_reset_req,
  input wire i_ilop_reset_req,
  input wire i_ilad_reset_req,
  input wire i_lowv_detect_enable,
  input wire i_lowv_detect_stop_enable,
  input wire i_lowv_reset_enable,
  input wire i_lowv_irq_enable,
  input wire i_lowv_ack,
  input wire i_lowv_trip_select,
  input wire i_lowv_warn_trip_select,
  input wire i_periodic_clock_select,
  input wire [2:0] i_periodic_period_select,
  input wire i_periodic_irq_enable,
  input wire i_periodic_ack,
  input wire i_stop_entry,
  input wire [1:0] i_stop_kind,
  input wire i_wake,
  input wire [`SRIC_VEC_COUNT-1:0] i_periph_req,
  input wire i_vector_fetch,
  output reg o_sys_reset,
  output reg [7:0] o_reset_cause,
  output reg o_lowv_active,
  output reg o_lowv_trip_select,
  output reg o_lowv_detect_flag,
  output reg o_lowv_warning,
  output reg o_periodic_irq_flag,
  output reg o_in_stop,
  output reg [1:0] o_stop_kind,
  output reg o_stop_refused,
  output reg o_wakeup,
  output reg o_irq_req,
  output reg [4:0] o_vector_num,
  output reg [15:0] o_vector_addr
);

  // ====================================================================
  // synchronisers for pins and foreign clocks
  // bit order: 32k, 1k, pin, warn_hi, warn_lo, below_hi, below_lo
  wire [6:0] async_in = {i_clk_32khz, i_clk_1khz, i_reset_pin,
    i_warn_below_hi, i_warn_below_lo, i_supply_below_hi, i_supply_below_lo};
  reg [6:0] sync1_reg;
  reg [6:0] sync2_reg;
  reg [1:0] clk_prev_reg;
  // supply comparators read as below trip out of reset, so the power-on hold
  // cannot end before the real supply level has crossed both flip-flops
  localparam [6:0] SYNC_RST = 7'h03;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      clk_prev_reg <= 2'h0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      clk_prev_reg <= sync2_reg[6:5];
    end
  end

  wire below_lo = sync2_reg[0];
  wire below_hi = sync2_reg[1];
  wire warn_lo = sync2_reg[2];
  wire warn_hi = sync2_reg[3];
  wire pin_rst = sync2_reg[4];
  wire tick_1k = sync2_reg[5] & ~clk_prev_reg[0];
  wire tick_32k = sync2_reg[6] & ~clk_prev_reg[1];

  // ====================================================================
  // stop mode tracking
  function sric_is_deep;
    input [1:0] kind;
    begin
      sric_is_deep = (kind == `SRIC_STOP_1) || (kind == `SRIC_STOP_2);
    end
  endfunction

  wire deep_req = sric_is_deep(i_stop_kind);
  wire refuse_deep = i_lowv_detect_enable & i_lowv_detect_stop_enable;
  wire in_deep = o_in_stop && sric_is_deep(o_stop_kind);
  reg periodic_wake;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_in_stop <= 1'b0;
      o_stop_kind <= 2'h0;
      o_stop_refused <= 1'b0;
      o_wakeup <= 1'b0;
    end else begin
      o_stop_refused <= 1'b0;
      o_wakeup <= 1'b0;
      if (o_sys_reset) begin
        o_in_stop <= 1'b0;
        o_stop_kind <= 2'h0;
      end else if (o_in_stop) begin
        if (i_wake || periodic_wake) begin
          o_in_stop <= 1'b0;
          o_stop_kind <= 2'h0;
          o_wakeup <= 1'b1;
        end
      end else if (i_stop_entry && i_stop_kind != 2'h0) begin
        if (deep_req && refuse_deep) begin
          o_stop_refused <= 1'b1;
        end else begin
          o_in_stop <= 1'b1;
          o_stop_kind <= i_stop_kind;
        end
      end
    end
  end

  // ====================================================================
  // low-voltage detector control
  // the analog comparators are only trusted while the detector is on
  wire lowv_on = i_lowv_detect_enable &&
    !(o_in_stop && !i_lowv_detect_stop_enable);
  wire below_sel = i_lowv_trip_select ? below_hi : below_lo;
  wire lowv_event = lowv_on & below_sel;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lowv_active <= 1'b0;
      o_lowv_trip_select <= 1'b0;
      o_lowv_warning <= 1'b0;
      o_lowv_detect_flag <= 1'b0;
    end else begin
      o_lowv_active <= lowv_on;
      o_lowv_trip_select <= i_lowv_trip_select;
      // warning is a status level only, never a request source
      o_lowv_warning <= lowv_on &
        (i_lowv_warn_trip_select ? warn_hi : warn_lo);
      if (lowv_event && i_lowv_irq_enable && !i_lowv_reset_enable) begin
        o_lowv_detect_flag <= 1'b1;
      end else if (i_lowv_ack) begin
        o_lowv_detect_flag <= 1'b0;
      end
    end
  end

  // ====================================================================
  // reset sequencing and cause capture
  localparam ST_POR = 2'h0;
  localparam ST_LOWV = 2'h1;
  localparam ST_OTHER = 2'h2;
  localparam ST_RUN = 2'h3;
  // the hold count is cut to the counter width on purpose
  localparam integer HOLD_CYC_I = `SRIC_RESET_HOLD_CYC;
  localparam [31:0] HOLD_CYC_W = HOLD_CYC_I;
  localparam [3:0] HOLD_CYC = HOLD_CYC_W[3:0];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] hold_reg;
  reg [3:0] hold_next;
  reg [7:0] cause_next;
  wire lowv_rst = lowv_event & i_lowv_reset_enable;
  wire other_rst = pin_rst | i_wdog_reset_req | i_ilop_reset_req |
    i_ilad_reset_req;

  always @* begin
    state_next = state_reg;
    hold_next = hold_reg;
    cause_next = o_reset_cause;
    case (state_reg)
      ST_POR: begin
        if (!below_lo) begin
          state_next = ST_RUN;
        end
      end
      ST_LOWV: begin
        if (!below_sel) begin
          state_next = ST_RUN;
        end
      end
      ST_OTHER: begin
        if (hold_reg != 4'h0) begin
          hold_next = hold_reg - 4'h1;
        end else if (!other_rst) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (lowv_rst) begin
          state_next = ST_LOWV;
          cause_next = 8'h00;
          cause_next[`SRIC_CAUSE_LOWV] = 1'b1;
        end else if (other_rst) begin
          state_next = ST_OTHER;
          hold_next = HOLD_CYC;
          cause_next = 8'h00;
          cause_next[`SRIC_CAUSE_PIN] = pin_rst;
          cause_next[`SRIC_CAUSE_WDOG] = i_wdog_reset_req;
          cause_next[`SRIC_CAUSE_ILOP] = i_ilop_reset_req;
          cause_next[`SRIC_CAUSE_ILAD] = i_ilad_reset_req;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_POR;
      hold_reg <= 4'h0;
      o_reset_cause <= `SRIC_CAUSE_RESET_VAL;
      o_sys_reset <= 1'b1;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      o_reset_cause <= cause_next;
      o_sys_reset <= (state_next != ST_RUN);
    end
  end

  // ====================================================================
  // periodic interrupt timer
  // in stop1/stop2 the 32 kHz source is gated off, so only 1 kHz wakes
  wire tick_sel = i_periodic_clock_select ? tick_32k : tick_1k;
  wire tick_ok = tick_sel &
    !(in_deep && i_periodic_clock_select);
  wire periodic_expire;

  sric_periodic_timer u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick_ok & ~o_sys_reset),
    .i_period_select(i_periodic_period_select),
    .o_expire(periodic_expire)
  );

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_periodic_irq_flag <= 1'b0;
      periodic_wake <= 1'b0;
    end else begin
      if (periodic_expire) begin
        o_periodic_irq_flag <= 1'b1;
      end else if (i_periodic_ack) begin
        o_periodic_irq_flag <= 1'b0;
      end
      periodic_wake <= periodic_expire & o_in_stop & i_periodic_irq_enable;
    end
  end

  // ====================================================================
  // request merge and vector selection
  reg [`SRIC_VEC_COUNT-1:0] req_all;

  always @* begin
    req_all = i_periph_req;
    req_all[`SRIC_VEC_NUM_LOWV] = o_lowv_detect_flag &
      i_lowv_irq_enable;
    req_all[`SRIC_VEC_NUM_PERIODIC] = o_periodic_irq_flag &
      i_periodic_irq_enable;
    // vectors 0 and 1 never come from here: reset has its own output
    req_all[0] = 1'b0;
    req_all[1] = 1'b0;
  end

  wire enc_any;
  wire [4:0] enc_num;
  wire [15:0] enc_addr;

  sric_vector_encoder u_enc (
    .i_req(req_all),
    .o_any(enc_any),
    .o_num(enc_num),
    .o_addr(enc_addr)
  );

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
      o_vector_num <= 5'h00;
      o_vector_addr <= `SRIC_VEC_RESET_ADDR;
    end else begin
      // requests are held off while the system sits in reset
      o_irq_req <= enc_any & ~o_sys_reset;
      if (o_sys_reset) begin
        o_vector_num <= 5'h00;
        o_vector_addr <= `SRIC_VEC_RESET_ADDR;
      end else if (i_vector_fetch) begin
        o_vector_num <= enc_num;
        o_vector_addr <= enc_addr;
      end
    end
  end

endmodule // sric_top

// ### rtl/sric_vector_encoder.v
`timescale 1ns/1ps
`include "sric_regs.vh"

module sric_vector_encoder (
  input wire [`SRIC_VEC_COUNT-1:0] i_req,
  output reg o_any,
  output reg [4:0] o_num,
  output reg [15:0] o_addr
);

  integer k;

  // ====================================================================
  // fixed priority: scan downward so the lowest number is kept last
  always @* begin
    o_any = 1'b0;
    o_num = 5'h00;
    for (k = `SRIC_VEC_COUNT - 1; k >= 0; k = k - 1) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_num = k[4:0];
      end
    end
    o_addr = `SRIC_VEC_RESET_ADDR - {10'h000, o_num, 1'b0};
  end

endmodule // sric_vector_encoder

// ### shared/sric_regs.vh
// Overview of operation
// - every reset cause uses the single top reset vector 0xFFFE:FFFF.
// - low-voltage detector works only while its enable bit is one.
// - detector trip level, high or low, comes from the trip select bit.
// - stop entry turns the detector off unless its stop enable is set.
// - with detector enable and stop enable set, stop1 and stop2 are refused.
// - power-on reset sets both power-on and low-voltage cause flags.
// - after power-on, reset holds until supply passes the low trip level.
// - with reset enable, low voltage resets; hold until above selected trip.
// - low-voltage reset also sets the low-voltage cause flag.
// - enabled detector with irq enable and no reset enable flags and requests.
// - warning flag has selectable trip level and never requests an interrupt.
// - periodic timer clock is 1 kHz or 32 kHz by the clock select bit.
// - periodic timer keeps running from either source in run, wait, stop3.
// - only the 1 kHz source can wake the part from stop1 or stop2.
// - periodic flag is read-only; writing one to acknowledge clears it.
// - a 3-bit period select picks one of seven wakeup periods.
// - period select of zero disables the timer, no interrupts.
// - periodic request reaches the cpu only while its enable is set.
// - control sits in one direct-page and eight high-page 8-bit registers.
// - each source sets its flag; request goes out only if enabled.
// - among pending requests the lowest vector number wins.
`ifndef SRIC_REGS_VH
`define SRIC_REGS_VH

// ======================================================================
// vectors
`define SRIC_VEC_RESET_ADDR 16'hfffe
`define SRIC_VEC_NUM_LOWV 5'h02
`define SRIC_VEC_NUM_PERIODIC 5'h17
`define SRIC_VEC_COUNT 24

// ======================================================================
// reset cause register bit positions
`define SRIC_CAUSE_POR 7
`define SRIC_CAUSE_PIN 6
`define SRIC_CAUSE_WDOG 5
`define SRIC_CAUSE_ILOP 4
`define SRIC_CAUSE_ILAD 3
`define SRIC_CAUSE_LOWV 1
`define SRIC_CAUSE_RESET_VAL 8'h82

// ======================================================================
// stop kinds
`define SRIC_STOP_1 2'h1
`define SRIC_STOP_2 2'h2
`define SRIC_STOP_3 2'h3

// ======================================================================
// periodic timer periods in source ticks, less one (count runs 0 to value)
`define SRIC_PER_1 10'h007
`define SRIC_PER_2 10'h01f
`define SRIC_PER_3 10'h03f
`define SRIC_PER_4 10'h07f
`define SRIC_PER_5 10'h0ff
`define SRIC_PER_6 10'h1ff
`define SRIC_PER_7 10'h3ff

// ======================================================================
// timing
`define SRIC_CLK_PERIOD_NS 8
`define SRIC_RESET_HOLD_NS 64
`define SRIC_RESET_HOLD_CYC \
  ((`SRIC_RESET_HOLD_NS + `SRIC_CLK_PERIOD_NS - 1) / `SRIC_CLK_PERIOD_NS)

`endif

// ### verif/sric_chk.sv
`timescale 1ns/1ps
`include "sric_regs.vh"
// ==========
// port checker
module sric_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wdog_reset_req,
  input wire logic i_ilop_reset_req,
  input wire logic i_ilad_reset_req,
  input wire logic i_lowv_detect_enable,
  input wire logic i_lowv_detect_stop_enable,
  input wire logic i_lowv_reset_enable,
  input wire logic i_lowv_irq_enable,
  input wire logic i_lowv_ack,
  input wire logic i_stop_entry,
  input wire logic [1:0] i_stop_kind,
  input wire logic [`SRIC_VEC_COUNT-1:0] i_periph_req,
  input wire logic i_vector_fetch,
  input wire logic o_sys_reset,
  input wire logic [7:0] o_reset_cause,
  input wire logic o_lowv_active,
  input wire logic o_lowv_detect_flag,
  input wire logic o_periodic_irq_flag,
  input wire logic o_in_stop,
  input wire logic o_stop_refused,
  input wire logic o_irq_req,
  input wire logic [4:0] o_vector_num,
  input wire logic [15:0] o_vector_addr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_fetch;
    i_vector_fetch && !o_sys_reset;
  endsequence
  sequence s_stop12;
    i_stop_entry && !o_in_stop && !o_sys_reset && i_stop_kind != 2'h3;
  endsequence
  property p_rst_vec;
    $fell(i_rst) |-> o_sys_reset && o_vector_addr == 16'hfffe
      && o_reset_cause == 8'h82;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("bad reset state");
  property p_refuse;
    s_stop12 ##0 (i_stop_kind != 2'h0 && i_lowv_detect_enable
      && i_lowv_detect_stop_enable) |=> o_stop_refused && !o_in_stop;
  endproperty
  a_refuse: assert property (p_refuse) else $error("deep stop taken");
  property p_det_off;
    !i_lowv_detect_enable |=> !o_lowv_active;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector on");
  property p_flag_set;
    $rose(o_lowv_detect_flag) |-> $past(i_lowv_irq_enable)
      && !$past(i_lowv_reset_enable);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set");
  property p_flag_hold;
    o_lowv_detect_flag && !i_lowv_ack ##1 !o_sys_reset |-> o_lowv_detect_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  // a warning alone must never raise a request
  property p_irq_src;
    $rose(o_irq_req) |-> $past(i_periph_req[22:3]) != 20'h0
      || $past(o_lowv_detect_flag) || $past(o_periodic_irq_flag);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("stray request");
  property p_vec_pair;
    s_fetch |=> o_vector_addr == 16'hfffe - {10'h0, o_vector_num, 1'b0};
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("vector pair");
  property p_wdog;
    i_wdog_reset_req && !i_ilop_reset_req && !i_ilad_reset_req
      && !o_sys_reset && !i_lowv_reset_enable
      |=> o_sys_reset && o_reset_cause == 8'h20;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset");
endmodule // sric_chk
bind sric_top sric_chk i_chk (.*);

// ### verif/sric_cpu_model.sv
`timescale 1ns/1ps
// ==========
// cpu side: fetches a vector some cycles after a request shows
module sric_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_irq_req,
  input wire logic i_sys_reset,
  input wire logic [3:0] i_delay,
  input wire logic [4:0] i_vector_num,
  output logic o_vector_fetch,
  output logic [4:0] o_taken_num
);
  logic [3:0] wait_reg;
  logic pend_reg;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_reg <= 4'h0;
      pend_reg <= 1'b0;
      o_vector_fetch <= 1'b0;
      o_taken_num <= 5'h00;
    end else begin
      pend_reg <= o_vector_fetch;
      o_vector_fetch <= 1'b0;
      // answer lands one edge after the fetch is sampled
      if (pend_reg)
        o_taken_num <= i_vector_num;
      if (!i_irq_req || i_sys_reset || o_vector_fetch || pend_reg)
        wait_reg <= 4'h0;
      else if (wait_reg == i_delay)
        o_vector_fetch <= 1'b1;
      else
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // sric_cpu_model

// ### verif/test_system_reset_interrupt_control.sv
`timescale 1ns/1ps
module test_system_reset_interrupt_control;
  logic i_clk, i_rst, i_supply_below_lo, i_supply_below_hi, i_warn_below_lo;
  logic i_warn_below_hi, i_reset_pin, i_clk_1khz, i_clk_32khz, i_wake;
  logic i_wdog_reset_req, i_ilop_reset_req, i_ilad_reset_req, i_lowv_ack;
  logic i_lowv_detect_enable, i_lowv_detect_stop_enable, i_lowv_reset_enable;
  logic i_lowv_irq_enable, i_lowv_trip_select, i_lowv_warn_trip_select;
  logic i_periodic_clock_select, i_periodic_irq_enable, i_periodic_ack;
  logic i_stop_entry, i_vector_fetch, o_sys_reset, o_lowv_active, o_wakeup;
  logic o_lowv_trip_select, o_lowv_detect_flag, o_lowv_warning, o_irq_req;
  logic o_periodic_irq_flag, o_in_stop, o_stop_refused, e;
  logic [1:0] i_stop_kind, o_stop_kind, src_run;
  logic [2:0] i_periodic_period_select;
  logic [3:0] cpu_delay;
  logic [4:0] o_vector_num, taken_num, n;
  logic [7:0] o_reset_cause;
  logic [15:0] o_vector_addr;
  logic [23:0] i_periph_req;
  logic [31:0] r;
  int n_fail, compares, cyc;
  sric_top i_dut (.*);
  sric_cpu_model i_cpu (.i_clk, .i_rst, .i_irq_req(o_irq_req),
    .i_sys_reset(o_sys_reset), .i_delay(cpu_delay),
    .i_vector_num(o_vector_num), .o_vector_fetch(i_vector_fetch),
    .o_taken_num(taken_num));
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;
  // ==========
  // slow sources run as data, eight cycles a tick, so periods stay short
  always @(posedge i_clk) begin
    #1;
    cyc++;
    i_clk_1khz = src_run[0] & cyc[2];
    i_clk_32khz = src_run[1] & cyc[2];
    if (cyc > 20000) begin
      n_fail++;
      results;
    end
  end
  task step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] x, input logic [15:0] got);
    compares++;
    if (got !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, got);
    end
  endtask
  task wait_rst(input logic v);
    int k;
    k = 0;
    while (o_sys_reset !== v && k < 400) begin
      step(1);
      k++;
    end
    chk("sys_reset", v, o_sys_reset);
  endtask
  function automatic logic [4:0] lowest(input logic [23:0] v);
    for (int j = 0; j < 24; j++)
      if (v[j]) return j[4:0];
    return 5'h00;
  endfunction
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {i_warn_below_lo, i_warn_below_hi, i_reset_pin, i_wake, i_lowv_ack} = '0;
    {i_wdog_reset_req, i_ilop_reset_req, i_ilad_reset_req, i_stop_entry} = '0;
    {i_lowv_detect_enable, i_lowv_detect_stop_enable, i_lowv_reset_enable} = '0;
    {i_lowv_irq_enable, i_lowv_trip_select, i_lowv_warn_trip_select} = '0;
    {i_periodic_clock_select, i_periodic_irq_enable, i_periodic_ack} = '0;
    {i_stop_kind, src_run, i_periodic_period_select, i_periph_req} = '0;
    {cyc, n_fail, compares, cpu_delay} = '0;
    {i_rst, i_supply_below_lo, i_supply_below_hi} = 3'b111;
    void'($urandom(32'h53b3));
    step(5);
    i_rst = 1'b0;
    step(8);
    chk("por_hold", 1, o_sys_reset);
    chk("por_cause", 8'h82, o_reset_cause);
    chk("reset_vec", 16'hfffe, o_vector_addr);
    {i_supply_below_lo, i_supply_below_hi} = 2'b00;
    wait_rst(0);
    $display("test por done");
    for (int i = 0; i < 12; i++) begin
      r = $urandom;
      {i_lowv_trip_select, i_lowv_irq_enable, i_lowv_detect_enable} = r[2:0];
      i_supply_below_hi = r[3];
      i_supply_below_lo = r[3] & r[4];
      i_lowv_warn_trip_select = r[5];
      i_warn_below_hi = r[6];
      i_warn_below_lo = r[6] & r[7];
      step(6);
      e = r[0] & r[1] & r[3] & (r[2] | r[4]);
      chk("lowv_flag", e, o_lowv_detect_flag);
      chk("irq_req", e, o_irq_req);
      chk("lowv_active", r[0], o_lowv_active);
      chk("trip_copy", r[2], o_lowv_trip_select);
      chk("warning", r[0] & r[6] & (r[5] | r[7]), o_lowv_warning);
      {i_supply_below_lo, i_supply_below_hi} = 2'b00;
      step(6);
      chk("lowv_hold", e, o_lowv_detect_flag);
      i_lowv_ack = 1'b1;
      step(1);
      i_lowv_ack = 1'b0;
      step(2);
      chk("lowv_ack", 0, o_lowv_detect_flag);
    end
    $display("test lowv irq done");
    {i_lowv_detect_enable, i_lowv_reset_enable, i_lowv_trip_select} = 3'b111;
    i_supply_below_hi = 1'b1;
    wait_rst(1);
    chk("lowv_cause", 8'h02, o_reset_cause);
    step(20);
    chk("lowv_held", 1, o_sys_reset);
    i_supply_below_hi = 1'b0;
    wait_rst(0);
    i_lowv_reset_enable = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {i_reset_pin, i_wdog_reset_req, i_ilop_reset_req, i_ilad_reset_req} =
        4'h8 >> i;
      wait_rst(1);
      chk("cause", 8'h40 >> i, o_reset_cause);
      {i_reset_pin, i_wdog_reset_req, i_ilop_reset_req, i_ilad_reset_req} = '0;
      wait_rst(0);
    end
    $display("test resets done");
    for (int k = 1; k < 4; k++)
      for (int s = 0; s < 2; s++) begin
        i_lowv_detect_stop_enable = s[0];
        i_stop_kind = k[1:0];
        i_stop_entry = 1'b1;
        step(1);
        i_stop_entry = 1'b0;
        e = s[0] && k != 3;
        chk("refused", e, o_stop_refused);
        chk("in_stop", !e, o_in_stop);
        if (!e)
          chk("stop_kind", k[1:0], o_stop_kind);
        step(2);
        chk("lowv_in_stop", s[0], o_lowv_active);
        i_wake = 1'b1;
        step(1);
        i_wake = 1'b0;
        chk("wakeup", !e, o_wakeup);
        step(2);
      end
    $display("test stop done");
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      i_periodic_clock_select = i[0];
      src_run = i[1] ? 2'b10 : 2'b01;
      i_periodic_period_select = (i == 4) ? 3'h0 : 3'h1;
      i_periodic_irq_enable = r[0];
      step(40);
      if (i == 0)
        chk("per_early", 0, o_periodic_irq_flag);
      step(60);
      e = i < 4 && i[0] == i[1];
      chk("per_flag", e, o_periodic_irq_flag);
      chk("per_irq", e & r[0], o_irq_req);
      i_periodic_period_select = 3'h0;
      src_run = 2'b00;
      step(4);
      i_periodic_ack = 1'b1;
      step(1);
      i_periodic_ack = 1'b0;
      step(2);
      chk("per_ack", 0, o_periodic_irq_flag);
    end
    $display("test periodic done");
    // the bench keeps the 32 kHz reference alive in stop, as software must
    i_lowv_detect_stop_enable = 1'b0;
    i_periodic_irq_enable = 1'b1;
    src_run = 2'b11;
    for (int k = 3; k > 0; k -= 2) begin
      i_periodic_clock_select = 1'b1;
      i_stop_kind = k[1:0];
      i_stop_entry = 1'b1;
      step(1);
      {i_stop_entry, i_periodic_period_select} = 4'h1;
      step(100);
      chk("stop_32k", k != 3, o_in_stop);
      i_periodic_clock_select = 1'b0;
      step(100);
      chk("wake_1k", 0, o_in_stop);
      chk("per_wake", 1, o_periodic_irq_flag);
      {i_periodic_period_select, i_periodic_ack} = 4'h1;
      step(2);
      i_periodic_ack = 1'b0;
    end
    {i_periodic_irq_enable, src_run} = '0;
    $display("test periodic wake done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      cpu_delay = r[3:0];
      i_periph_req = {1'b0, r[27:8] | 20'h80000, 3'h0};
      n = lowest(i_periph_req);
      step(40);
      chk("irq_any", 1, o_irq_req);
      chk("vec_num", n, taken_num);
      chk("vec_addr", 16'hfffe - {10'h0, n, 1'b0}, o_vector_addr);
    end
    i_periph_req = '0;
    step(4);
    chk("irq_none", 0, o_irq_req);
    $display("test vectors done");
    results;
  end
endmodule // test_system_reset_interrupt_control
